// File: hw/fbm_ctrl.sv
// Host controller that drives a byte-wide flash over its control pins
//
// Overview of operation
// - Erase, program, lock need two writes
// - Read needs chip-select and output-enable low
// - During read keep write-enable, reset high
// - Write read-mode command before reading
// - Reset low: power-down, minimum pulse, wake wait
// - Wait recovery time before command write
// - Flash reset follows processor reset
// - Host checks status after each operation; the sequencer reads status only after two-write sequences
//
// Chosen here: the APB slave port and the register offsets.
module fbm_ctrl #(
  parameter int ADDR_W = 21
) (
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic                   chip_select_n_out,
  output logic                   output_enable_n_out,
  output logic                   write_enable_n_out,
  output logic                   reset_powerdown_n_out,
  output logic                   override_high_level_out,
  output logic      [ADDR_W-1:0] address_out,
  input  wire logic [7:0]        data_lines_in,
  output logic      [7:0]        data_lines_out,
  output logic                   data_lines_oe_out,
  input  wire logic              ready_busy_in
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [fbm_pkg::TMR_W-1:0] PD_T   = fbm_pkg::TMR_W'(fbm_pkg::PD_CYC);
  localparam logic [fbm_pkg::TMR_W-1:0] WAKE_T = fbm_pkg::TMR_W'(fbm_pkg::WAKE_CYC);
  localparam logic [fbm_pkg::TMR_W-1:0] RD_T   = fbm_pkg::TMR_W'(fbm_pkg::RD_CYC);
  localparam logic [fbm_pkg::TMR_W-1:0] WE_T   = fbm_pkg::TMR_W'(fbm_pkg::WE_CYC);
  localparam logic [fbm_pkg::TMR_W-1:0] SET_T  = fbm_pkg::TMR_W'(fbm_pkg::SETTLE_CYC);

  fbm_pkg::fbm_state_e state_reg, state_next;   // Sequencer state
  logic [31:0]       ctrl_reg,  ctrl_next;     // Control register
  logic [ADDR_W-1:0] addr_reg,  addr_next;     // Target address
  logic [15:0]       wdata_reg, wdata_next;    // First and second byte
  logic [7:0]        rdata_reg, rdata_next;    // Last byte read
  logic              done_reg,  done_next;     // Sticky done flag
  logic              start_reg, start_next;    // Start request
  logic              cmd_reg,   cmd_next;      // Two-write operation
  logic              sec_reg,   sec_next;      // Second write pending
  logic              ce_n_reg,  ce_n_next;     // Pin registers
  logic              oe_n_reg,  oe_n_next;
  logic              we_n_reg,  we_n_next;
  logic              rp_n_reg,  rp_n_next;
  logic              ovr_reg,   ovr_next;
  logic [ADDR_W-1:0] aout_reg,  aout_next;
  logic [7:0]        dout_reg,  dout_next;
  logic              doe_reg,   doe_next;
  logic [31:0]       prdata_reg, prdata_next;  // Bus answer
  logic              pready_reg, pready_next;
  logic              pslverr_reg, pslverr_next;
  logic              tmr_load;                 // Timer load strobe
  logic [fbm_pkg::TMR_W-1:0] tmr_count;        // Timer load value
  logic              tmr_done;                 // Interval elapsed
  logic [7:0]        data_sync;                // Synchronised data lines
  logic              rb_sync;                  // Synchronised ready/busy
  logic              acc_wr;                   // Write taking effect
  logic              hit;                      // Mapped address
  logic [31:0]       rd_mux;                   // Read data mux

  // ----------------------------------------------------------------
  // Pin synchronisers and interval timer
  // ----------------------------------------------------------------
  fbm_sync #(.W(9)) fbm_sync_i (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .async_in ({ready_busy_in, data_lines_in}),
    .sync_out ({rb_sync, data_sync})
  );

  fbm_timer #(.W(fbm_pkg::TMR_W), .RST_CNT(PD_T)) fbm_timer_i (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .load_in  (tmr_load),
    .count_in (tmr_count),
    .done_out (tmr_done)
  );

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase, pready set in setup
  // ----------------------------------------------------------------
  assign acc_wr = psel_in && penable_in && pready_reg && pwrite_in;
  assign hit    = (paddr_in == fbm_pkg::OFF_CTRL)  || (paddr_in == fbm_pkg::OFF_ADDR) ||
                  (paddr_in == fbm_pkg::OFF_WDATA) || (paddr_in == fbm_pkg::OFF_STATUS);

  // Read mux; reserved bits read zero, but CTRL returns every bit written except start
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_in)
      fbm_pkg::OFF_CTRL:   rd_mux = ctrl_reg;
      fbm_pkg::OFF_ADDR:   rd_mux = 32'(addr_reg);
      fbm_pkg::OFF_WDATA:  rd_mux = {16'h0000, wdata_reg};
      fbm_pkg::OFF_STATUS: begin
        rd_mux[fbm_pkg::ST_BUSY] = (state_reg != fbm_pkg::S_IDLE) || start_reg;
        rd_mux[fbm_pkg::ST_RB]   = rb_sync;
        rd_mux[fbm_pkg::ST_DONE] = done_reg;
        rd_mux[fbm_pkg::ST_RD_LSB +: 8] = rdata_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus answer and register writes
  always_comb begin
    pready_next  = psel_in && !penable_in;
    pslverr_next = psel_in && !penable_in && !hit;
    prdata_next  = (psel_in && !penable_in) ? rd_mux : prdata_reg;
    ctrl_next    = ctrl_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    start_next   = start_reg;
    if (acc_wr) begin
      case (paddr_in)
        fbm_pkg::OFF_CTRL: begin
          ctrl_next = pwdata_in;
          ctrl_next[fbm_pkg::CTRL_START] = 1'b0;
          // Start only when idle; otherwise the request is dropped
          if (pwdata_in[fbm_pkg::CTRL_START] && state_reg == fbm_pkg::S_IDLE) begin
            start_next = 1'b1;
          end
        end
        fbm_pkg::OFF_ADDR:  addr_next  = pwdata_in[ADDR_W-1:0];
        fbm_pkg::OFF_WDATA: wdata_next = pwdata_in[15:0];
        default: ;
      endcase
    end
    if (state_reg == fbm_pkg::S_IDLE && start_reg) begin
      start_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    ce_n_next  = ce_n_reg;
    oe_n_next  = oe_n_reg;
    we_n_next  = we_n_reg;
    rp_n_next  = rp_n_reg;
    ovr_next   = ovr_reg;
    aout_next  = aout_reg;
    dout_next  = dout_reg;
    doe_next   = doe_reg;
    rdata_next = rdata_reg;
    cmd_next   = cmd_reg;
    sec_next   = sec_reg;
    done_next  = done_reg;
    tmr_load   = 1'b0;
    tmr_count  = RD_T;
    // Software clears done by writing one; a new completion wins
    if (acc_wr && paddr_in == fbm_pkg::OFF_STATUS && pwdata_in[fbm_pkg::ST_DONE]) begin
      done_next = 1'b0;
    end
    case (state_reg)
      fbm_pkg::S_IDLE: begin
        // Elevated level only changes between operations
        ovr_next = ctrl_reg[fbm_pkg::CTRL_OVR] && rp_n_reg;
        if (start_reg) begin
          aout_next = addr_reg;
          case (fbm_pkg::fbm_op_e'(ctrl_reg[fbm_pkg::CTRL_OP_LSB +: 2]))
            fbm_pkg::OP_READ: begin
              // Select and enable outputs together, write strobe high
              ce_n_next  = 1'b0;
              oe_n_next  = 1'b0;
              tmr_load   = 1'b1;
              tmr_count  = RD_T;
              state_next = fbm_pkg::S_READ;
            end
            fbm_pkg::OP_PDOWN: begin
              // Drop reset pin with the bus idle
              rp_n_next  = 1'b0;
              ovr_next   = 1'b0;
              tmr_load   = 1'b1;
              tmr_count  = PD_T;
              state_next = fbm_pkg::S_PDLOW;
            end
            default: begin
              // Single write (read-mode command) or two-write sequence
              cmd_next   = (ctrl_reg[fbm_pkg::CTRL_OP_LSB +: 2] == fbm_pkg::OP_CMD);
              sec_next   = (ctrl_reg[fbm_pkg::CTRL_OP_LSB +: 2] == fbm_pkg::OP_CMD);
              dout_next  = wdata_reg[7:0];
              doe_next   = 1'b1;
              ce_n_next  = 1'b0;
              state_next = fbm_pkg::S_SETUP;
            end
          endcase
        end
      end
      fbm_pkg::S_SETUP: begin
        // Address and data settled, strobe low
        we_n_next  = 1'b0;
        tmr_load   = 1'b1;
        tmr_count  = WE_T;
        state_next = fbm_pkg::S_WLOW;
      end
      fbm_pkg::S_WLOW: begin
        if (tmr_done) begin
          // Write strobe rises first, so it is the latching edge
          we_n_next  = 1'b1;
          state_next = fbm_pkg::S_WHOLD;
        end
      end
      fbm_pkg::S_WHOLD: begin
        ce_n_next = 1'b1;
        if (sec_reg) begin
          // Second cycle of the command sequence
          sec_next   = 1'b0;
          dout_next  = wdata_reg[15:8];
          ce_n_next  = 1'b0;
          state_next = fbm_pkg::S_SETUP;
        end else if (cmd_reg) begin
          doe_next   = 1'b0;
          tmr_load   = 1'b1;
          tmr_count  = SET_T;
          state_next = fbm_pkg::S_BUSY;
        end else begin
          doe_next   = 1'b0;
          done_next  = 1'b1;
          state_next = fbm_pkg::S_IDLE;
        end
      end
      fbm_pkg::S_BUSY: begin
        // Wait for ready, then read the status byte the device presents
        if (tmr_done && rb_sync) begin
          ce_n_next  = 1'b0;
          oe_n_next  = 1'b0;
          tmr_load   = 1'b1;
          tmr_count  = RD_T;
          state_next = fbm_pkg::S_READ;
        end
      end
      fbm_pkg::S_READ: begin
        if (tmr_done) begin
          rdata_next = data_sync;
          ce_n_next  = 1'b1;
          oe_n_next  = 1'b1;
          cmd_next   = 1'b0;
          done_next  = 1'b1;
          state_next = fbm_pkg::S_IDLE;
        end
      end
      fbm_pkg::S_PDLOW: begin
        // Least pulse met and no hold requested
        if (tmr_done && !ctrl_reg[fbm_pkg::CTRL_PDHOLD]) begin
          rp_n_next  = 1'b1;
          tmr_load   = 1'b1;
          tmr_count  = WAKE_T;
          state_next = fbm_pkg::S_WAKE;
        end
      end
      fbm_pkg::S_WAKE: begin
        // Recovery before any read or command write
        if (tmr_done) begin
          done_next  = 1'b1;
          state_next = fbm_pkg::S_IDLE;
        end
      end
      default: state_next = fbm_pkg::S_IDLE;
    endcase
  end

  // Registers; reset holds the flash in power-down with the system
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg   <= fbm_pkg::S_PDLOW;
      ctrl_reg    <= fbm_pkg::CTRL_RST;
      addr_reg    <= '0;
      wdata_reg   <= 16'h0000;
      rdata_reg   <= 8'h00;
      done_reg    <= 1'b0;
      start_reg   <= 1'b0;
      cmd_reg     <= 1'b0;
      sec_reg     <= 1'b0;
      ce_n_reg    <= 1'b1;
      oe_n_reg    <= 1'b1;
      we_n_reg    <= 1'b1;
      rp_n_reg    <= 1'b0;
      ovr_reg     <= 1'b0;
      aout_reg    <= '0;
      dout_reg    <= 8'h00;
      doe_reg     <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ctrl_reg    <= ctrl_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      rdata_reg   <= rdata_next;
      done_reg    <= done_next;
      start_reg   <= start_next;
      cmd_reg     <= cmd_next;
      sec_reg     <= sec_next;
      ce_n_reg    <= ce_n_next;
      oe_n_reg    <= oe_n_next;
      we_n_reg    <= we_n_next;
      rp_n_reg    <= rp_n_next;
      ovr_reg     <= ovr_next;
      aout_reg    <= aout_next;
      dout_reg    <= dout_next;
      doe_reg     <= doe_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata_out              = prdata_reg;
  assign pready_out              = pready_reg;
  assign pslverr_out             = pslverr_reg;
  assign chip_select_n_out       = ce_n_reg;
  assign output_enable_n_out     = oe_n_reg;
  assign write_enable_n_out      = we_n_reg;
  assign reset_powerdown_n_out   = rp_n_reg;
  assign override_high_level_out = ovr_reg;
  assign address_out             = aout_reg;
  assign data_lines_out          = dout_reg;
  assign data_lines_oe_out       = doe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] lo_cnt;   // Cycles reset pin low
  logic [7:0] hi_cnt;   // Cycles since reset pin rose
  logic [1:0] we_cnt;   // Strobes in current operation

  // Helper counters for the checks
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lo_cnt <= 8'h00;
      hi_cnt <= 8'h00;
      we_cnt <= 2'h0;
    end else begin
      lo_cnt <= rp_n_reg ? 8'h00 : ((lo_cnt == 8'hFF) ? lo_cnt : lo_cnt + 8'h01);
      hi_cnt <= !rp_n_reg ? 8'h00 : ((hi_cnt == 8'hFF) ? hi_cnt : hi_cnt + 8'h01);
      if (state_reg == fbm_pkg::S_IDLE) begin
        we_cnt <= 2'h0;
      end else if (we_n_reg && !we_n_next) begin
        we_cnt <= we_cnt + 2'h1;
      end
    end
  end

  a_pd_pulse_len: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(rp_n_reg) |-> $past(lo_cnt) >= 8'(fbm_pkg::PD_CYC))
    else $error("reset pin low pulse too short");
  a_wake_to_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(we_n_reg) |-> hi_cnt >= 8'(fbm_pkg::WRITE_CYC))
    else $error("write before recovery time");
  a_wake_to_read: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(oe_n_reg) |-> hi_cnt >= 8'(fbm_pkg::VALID_CYC))
    else $error("read before wake-up time");
  a_read_pins_high: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !oe_n_reg |-> we_n_reg && rp_n_reg)
    else $error("read with write strobe or reset low");
  a_read_select: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_reg == fbm_pkg::S_READ) && tmr_done |-> !ce_n_reg && !oe_n_reg && !doe_reg)
    else $error("read sampled without select and enable");
  a_two_writes: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(state_reg == fbm_pkg::S_BUSY) |-> we_cnt == 2'h2)
    else $error("command sequence without two writes");
  a_status_poll: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (state_reg == fbm_pkg::S_BUSY) && tmr_done && rb_sync
      |=> (state_reg == fbm_pkg::S_READ) && !oe_n_reg ##5 done_reg)
    else $error("status not read after operation");
  a_strobe_order: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(ce_n_reg) |-> $past(we_n_reg) && we_n_reg)
    else $error("select rose before write strobe");
  a_pd_quiet: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !rp_n_reg |-> ce_n_reg && oe_n_reg && we_n_reg && !doe_reg && !ovr_reg)
    else $error("bus active during power-down");
endmodule : fbm_ctrl

// File: hw/fbm_pkg.sv
// Package: constants, register map and types of the flash bus-mode controller
package fbm_pkg;
  // ----------------------------------------------------------------
  // Clock and pin timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 100;  // 10 MHz system clock
  localparam int POWERDOWN_PULSE_MIN_NS = 100;  // Least low time of reset pin
  localparam int WAKEUP_TO_VALID_NS   = 400;  // Release to first valid read
  localparam int WAKEUP_TO_WRITE_NS   = 1000; // Release to first command write
  localparam int READ_ACCESS_NS       = 100;  // Select to data valid
  localparam int WE_LOW_NS            = 100;  // Write strobe width
  localparam int SYNC_STAGES          = 2;    // Pin synchroniser depth
  localparam int PD_CYC    = (POWERDOWN_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VALID_CYC = (WAKEUP_TO_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (WAKEUP_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYC  = (VALID_CYC > WRITE_CYC) ? VALID_CYC : WRITE_CYC;
  localparam int RD_CYC    = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                             + SYNC_STAGES + 1;
  localparam int WE_CYC    = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = SYNC_STAGES + 2; // Busy line settle before polling
  localparam int TMR_W     = 8;               // Timer width
  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_ADDR   = 8'h04;
  localparam logic [7:0] OFF_WDATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam int CTRL_START  = 0;  // Write 1 starts an operation
  localparam int CTRL_OP_LSB = 1;  // Two-bit operation code
  localparam int CTRL_OVR    = 3;  // Elevated reset level request
  localparam int CTRL_PDHOLD = 4;  // Keep device in power-down
  localparam int ST_BUSY     = 0;  // Controller busy
  localparam int ST_RB       = 1;  // Synchronised ready/busy line
  localparam int ST_DONE     = 2;  // Sticky done, write 1 clears
  localparam int ST_RD_LSB   = 8;  // Last byte read
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_CMD   = 2'h2,
    OP_PDOWN = 2'h3
  } fbm_op_e;
  typedef enum logic [7:0] {
    S_IDLE  = 8'h01,
    S_SETUP = 8'h02,
    S_WLOW  = 8'h04,
    S_WHOLD = 8'h08,
    S_READ  = 8'h10,
    S_BUSY  = 8'h20,
    S_PDLOW = 8'h40,
    S_WAKE  = 8'h80
  } fbm_state_e;
endpackage : fbm_pkg

// File: hw/fbm_sync.sv
// Two flip-flop synchroniser for pin inputs
module fbm_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_reg; // First stage, read only by second

  // Two stages, reset to zero
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : fbm_sync

// File: hw/fbm_timer.sv
// Loadable down counter used for pin timing intervals
module fbm_timer #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_CNT = '0
) (
  input  wire logic         clock_in,
  input  wire logic         rstn_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] count_in,
  output logic              done_out
);
  logic [W-1:0] cnt_reg;  // Remaining cycles
  logic [W-1:0] cnt_next; // Next count

  // Load wins, else count down to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (load_in) begin
      cnt_next = count_in;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  // Count register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_reg <= RST_CNT;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_out = (cnt_reg == '0);
endmodule : fbm_timer

// File: sim/fbm_ctrl_tb_top.sv
// Self-checking testbench of the flash bus-mode controller
`define CHK(nm, ex, got) begin samples_checked++; if ((ex) !== (got)) begin errors++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module fbm_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in, rstn_in, psel, penable, pwrite, pready, pslverr;
  logic        ce_n, oe_n, we_n, rp_n, ovr, host_oe, dev_oe, rdy;
  logic [7:0]  paddr, host_d, dev_d, to_host, to_dev, a1, a2, pb;
  logic [7:0]  idle_pat = 8'h00;  // Value seen on the undriven bus
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] addr;
  logic [32:0] exp_q[$];  // Expected {pslverr, prdata}
  logic [32:0] msk_q[$];  // Bits that matter
  int          errors, samples_checked, seed;
  // Undriven bus wanders every cycle
  assign to_host = dev_oe ? dev_d : (host_oe ? host_d : idle_pat);
  assign to_dev = host_oe ? host_d : idle_pat;
  fbm_ctrl fbm_ctrl_i (.clock_in(clock_in), .rstn_in(rstn_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .chip_select_n_out(ce_n), .output_enable_n_out(oe_n), .write_enable_n_out(we_n),
    .reset_powerdown_n_out(rp_n), .override_high_level_out(ovr), .address_out(addr),
    .data_lines_in(to_host), .data_lines_out(host_d), .data_lines_oe_out(host_oe),
    .ready_busy_in(rdy));
  fbm_flash_model fbm_flash_model_i (.clock_in(clock_in), .chip_select_n_in(ce_n),
    .output_enable_n_in(oe_n), .write_enable_n_in(we_n), .reset_powerdown_n_in(rp_n),
    .override_high_level_in(ovr),
    .address_in(addr), .data_in(to_dev), .data_out(dev_d), .data_oe_out(dev_oe),
    .ready_busy_out(rdy));
  // Clock
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) idle_pat <= idle_pat + 8'h3B;
  // Monitor takes the oldest note at each completed read
  always @(posedge clock_in) begin
    if (psel && penable && pready && !pwrite) begin
      `CHK("apb read", exp_q[0], {pslverr, prdata} & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  // One APB transfer; reads leave a note
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] ex, input logic [32:0] mk);
    if (!w) begin
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
    end
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll until done, then clear it
  task wait_done;
    rd = '0;
    while (rd[fbm_pkg::ST_DONE] !== 1'b1) begin
      apb(1'b0, fbm_pkg::OFF_STATUS, '0, '0, 33'h1_0000_0000);
    end
    apb(1'b1, fbm_pkg::OFF_STATUS, 32'h4, '0, '0);
  endtask : wait_done
  // Start an operation and wait for it; top bit asks for the override level
  task op(input logic [2:0] o);
    apb(1'b1, fbm_pkg::OFF_CTRL, {28'h0, o, 1'b1}, '0, '0);
    wait_done();
  endtask : op
  // Expect a read byte in STATUS
  task rbyte(input logic [7:0] b);
    apb(1'b0, fbm_pkg::OFF_STATUS, '0, {17'h0, b, 8'h0}, 33'h1_0000_FF00);
  endtask : rbyte
  task summarize;
    $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    #(5000 * 100);
    errors++;
    summarize();
  end
  // Main sequence
  initial begin
    seed = 32'h4bfbc7f2;
    errors = 0;
    samples_checked = 0;
    rstn_in = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    a1 = {1'b0, 7'($random(seed))};  // Unlocked lower half
    a2 = {1'b1, 7'($random(seed))};  // Locked upper half, needs override
    pb = 8'($random(seed));
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    wait_done();
    apb(1'b0, fbm_pkg::OFF_STATUS, '0, 33'h2, 33'h1_0000_0007);
    apb(1'b1, fbm_pkg::OFF_ADDR, {24'h0, a1}, '0, '0);
    op(3'h0);
    rbyte(a1 ^ 8'hA5);
    apb(1'b0, 8'h10, '0, {1'b1, 32'h0}, '1);
    apb(1'b1, fbm_pkg::OFF_ADDR, {24'h0, a2}, '0, '0);
    apb(1'b1, fbm_pkg::OFF_WDATA, {16'h0, pb, 8'h40}, '0, '0);
    op(3'h6);
    rbyte(8'h80);
    apb(1'b1, fbm_pkg::OFF_WDATA, 32'hFF, '0, '0);
    op(3'h1);
    op(3'h0);
    rbyte(pb);
    apb(1'b1, fbm_pkg::OFF_WDATA, 32'h70, '0, '0);
    op(3'h1);
    apb(1'b1, fbm_pkg::OFF_ADDR, {24'h0, a1}, '0, '0);
    apb(1'b1, fbm_pkg::OFF_CTRL, 32'h17, '0, '0);
    repeat (4) @(posedge clock_in);
    `CHK("reset pin held", 1'b0, rp_n)
    apb(1'b1, fbm_pkg::OFF_CTRL, 32'h0, '0, '0);
    wait_done();
    op(3'h0);
    rbyte(a1 ^ 8'hA5);
    summarize();
  end
endmodule : fbm_ctrl_tb_top

// File: sim/fbm_flash_model.sv
// Behavioural model of the byte-wide flash device on the controller's pins
module fbm_flash_model #(
  parameter int BUSY_CYC       = 6,   // Program time in clocks
  parameter bit PROG_SUPPLY_OK = 1'b1 // Program supply above its lockout level
) (
  input  wire logic        clock_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        output_enable_n_in,
  input  wire logic        write_enable_n_in,
  input  wire logic        reset_powerdown_n_in,
  input  wire logic        override_high_level_in,
  input  wire logic [20:0] address_in,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_out,
  output logic             ready_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_reg [0:255];  // Small array, low address bits only
  logic       status_mode_reg;  // High when reads return status
  logic       armed_reg;        // Program setup byte seen
  logic       susp_reg;         // Operation suspended, array readable
  int         busy_cnt;         // Remaining busy clocks
  // Power-up contents and read array mode
  initial begin
    status_mode_reg = 1'b0;
    armed_reg = 1'b0;
    susp_reg = 1'b0;
    busy_cnt = 0;
    for (int i = 0; i < 256; i++) mem_reg[i] = 8'(i) ^ 8'hA5;
  end
  // Command latch on the rising write strobe; writes ignored in reset or deselected, only suspend and resume while busy
  always @(posedge write_enable_n_in) begin
    if (reset_powerdown_n_in && !chip_select_n_in) begin
      if (busy_cnt > 0 || susp_reg) begin
        // Only suspend and resume are taken while an operation is open
        if (data_in == 8'hB0) susp_reg = 1'b1;
        if (data_in == 8'hD0) susp_reg = 1'b0;
        status_mode_reg = !susp_reg;
      end else if (armed_reg) begin
        // Upper half is locked: needs override; low supply keeps the array
        if (PROG_SUPPLY_OK && (!address_in[7] || override_high_level_in)) begin
          mem_reg[address_in[7:0]] = data_in;
        end
        armed_reg = 1'b0;
        busy_cnt = BUSY_CYC;
      end else begin
        armed_reg = (data_in == 8'h40) || (data_in == 8'h10);
        status_mode_reg = (data_in != 8'hFF);
      end
    end
  end
  // Reset pin low aborts work and wakes in read array mode
  always @(negedge reset_powerdown_n_in) begin
    busy_cnt = 0;
    armed_reg = 1'b0;
    susp_reg = 1'b0;
    status_mode_reg = 1'b0;
  end
  // Program timer, runs on when deselected, holds while suspended
  always @(posedge clock_in) if (busy_cnt > 0 && !susp_reg) busy_cnt--;
  assign ready_busy_out = (busy_cnt == 0) || susp_reg;
  assign data_oe_out = reset_powerdown_n_in && !chip_select_n_in && !output_enable_n_in;
  // Status byte is 80h when ready, 00h while working
  assign data_out = (status_mode_reg || (busy_cnt > 0 && !susp_reg)) ? {ready_busy_out, 7'h00}
                                                       : mem_reg[address_in[7:0]];
endmodule : fbm_flash_model
